/* File: pkg/pcx_pkg.sv */
// Constants and carrier types of the peripheral controller instruction unit
package pcx_pkg;

  // ------------------------------------------------------------------
  // APB register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] PCX_CTRL_OFS = 8'h00;
  localparam logic [7:0] PCX_PADDR_OFS = 8'h04;
  localparam logic [7:0] PCX_PDATA_OFS = 8'h08;
  localparam logic [7:0] PCX_CORE_OFS = 8'h0C;
  localparam logic [7:0] PCX_HOST_OFS = 8'h10;
  localparam logic [7:0] PCX_DADDR_OFS = 8'h14;
  localparam logic [7:0] PCX_DDATA_OFS = 8'h18;

  // ------------------------------------------------------------------
  // Field positions, reset values, memory layout
  // ------------------------------------------------------------------
  localparam int PCX_CTRL_RUN_BIT = 0;
  localparam int PCX_DMA_REQ_BIT = 6;
  localparam int PCX_PC_W = 10;
  localparam int PCX_PMEM_DEPTH = 1024;
  localparam int PCX_DMEM_DEPTH = 64;
  localparam logic [7:0] PCX_ACC_RST = 8'h00;
  localparam logic [7:0] PCX_PORT_RST = 8'hFF;
  localparam logic [9:0] PCX_PC_RST = 10'h000;
  localparam logic [1:0] PCX_PAGE3 = 2'h3;
  localparam logic [5:0] PCX_BANK0_BASE = 6'h00;
  localparam logic [5:0] PCX_BANK1_BASE = 6'h18;

  // ------------------------------------------------------------------
  // Opcodes and family masks
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_MASK_P = 8'hFC;
  localparam logic [7:0] OP_MASK_R = 8'hF8;
  localparam logic [7:0] OP_MASK_I = 8'hFE;
  localparam logic [7:0] OP_ANL_P = 8'h98;
  localparam logic [7:0] OP_ORL_P = 8'h88;
  localparam logic [7:0] OP_IN_P = 8'h08;
  localparam logic [7:0] OP_OUTL_P = 8'h38;
  localparam logic [7:0] OP_EXP_RD = 8'h0C;
  localparam logic [7:0] OP_EXP_WR = 8'h3C;
  localparam logic [7:0] OP_EXP_AND = 8'h9C;
  localparam logic [7:0] OP_EXP_OR = 8'h8C;
  localparam logic [7:0] OP_MOV_R_IMM = 8'hB8;
  localparam logic [7:0] OP_MOV_I_IMM = 8'hB0;
  localparam logic [7:0] OP_MOV_I_A = 8'hA0;
  localparam logic [7:0] OP_XCH_I = 8'h20;
  localparam logic [7:0] OP_DIGIT_XCHG = 8'h30;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h23;
  localparam logic [7:0] OP_IN_HOST = 8'h22;
  localparam logic [7:0] OP_OUT_HOST = 8'h02;
  localparam logic [7:0] OP_STATUS_LD = 8'h90;
  localparam logic [7:0] OP_MOVP = 8'hA3;
  localparam logic [7:0] OP_MOVP3 = 8'hE3;
  localparam logic [7:0] OP_TIRQ_EN = 8'h25;
  localparam logic [7:0] OP_TIRQ_DIS = 8'h35;
  localparam logic [7:0] OP_DMA_EN = 8'hE5;
  localparam logic [7:0] OP_BANK0 = 8'hC5;
  localparam logic [7:0] OP_BANK1 = 8'hD5;

  // Expander command codes sent on the low port lines
  localparam logic [1:0] EXP_CMD_RD = 2'h0;
  localparam logic [1:0] EXP_CMD_WR = 2'h1;
  localparam logic [1:0] EXP_CMD_OR = 2'h2;
  localparam logic [1:0] EXP_CMD_AND = 2'h3;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
    logic dma_acknowledge_line_n;
    logic [7:0] data;
  } pcx_host_in_t;

  typedef struct packed {
    logic strobe;
    logic lo_oe;
    logic [3:0] lo;
  } pcx_exp_out_t;

  typedef enum logic [2:0] {
    S_HALT = 3'b001,
    S_RUN = 3'b010,
    S_SEC = 3'b100
  } pcx_state_t;

endpackage : pcx_pkg

/* File: design/pcx_core.sv */
// Instruction unit of the slave peripheral controller
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps

// How it works
// RL1: AND-immediate to port is two bytes, two cycles, writes result back.
// RL2: OR-immediate to port is two bytes, two cycles, merges into latch.
// RL3: Host buffer read into A is one cycle and clears input-full flag.
// RL4: A to host output buffer is one cycle and sets output-full flag.
// RL5: Status load copies A bits 4-7 to status bits 4-7, one cycle.
// RL6: Expander read is one byte, two cycles, nibble via low lines and strobe.
// RL7: Expander write is one byte and takes two cycles.
// RL8: Expander AND sends A for ANDing into expander port, two cycles.
// RL9: Expander OR sends A for ORing into expander port, two cycles.
// RL10: Table lookup loads A from current page or page 3, two cycles.
// RL11: Immediate to working register takes two bytes, two cycles.
// RL12: Immediate to indirect data memory takes two bytes, two cycles.
// RL13: A to indirect data memory is one byte, one cycle.
// RL14: Digit exchange swaps low nibbles of A and memory in one cycle.
// RL15: Exchange swaps A and indirect memory byte in one cycle.
// RL16: One-cycle instruction enables timer overflow interrupt.
// RL17: One-cycle instruction disables timer overflow interrupt.
// RL18: One-cycle instruction turns upper port 2 lines into DMA handshake.
// RL19: Two one-cycle instructions select register bank 0 or 1.
// RL20: Status load leaves status bits 0-3 untouched.
// RL21: Status load opcode is the single byte 90H.
// RL22: DMA request drops on acknowledged read/write or handshake re-enable.
// RL23: Two-byte instructions take second byte as operand, PC skips both.
module pcx_core
  import pcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcx_host_in_t host_in,
  output logic [7:0] host_dout,
  output logic host_doe,
  input wire logic [7:0] p1_i,
  output logic [7:0] p1_o,
  input wire logic [7:0] p2_i,
  output logic [7:0] p2_o,
  output pcx_exp_out_t exp_o,
  output logic dma_request_line,
  output logic timer_irq_enable
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0] pmem_r [PCX_PMEM_DEPTH];
  logic [7:0] dmem_r [PCX_DMEM_DEPTH];
  pcx_state_t st_r;
  logic run_r;
  logic [9:0] pc_r;
  logic [9:0] pm_addr_r;
  logic [5:0] dm_addr_r;
  logic [7:0] op_r;
  logic [7:0] acc_r;
  logic [7:0] p1_r;
  logic [7:0] p2_r;
  logic bank_r;
  logic tirq_en_r;
  logic dma_en_r;
  logic dma_req_r;
  logic in_full_r;
  logic out_full_r;
  logic f1_r;
  logic [3:0] host_status_nibble_r;
  logic [7:0] in_buf_r;
  logic [7:0] out_buf_r;
  logic rd_act_r;
  logic wr_act_r;
  logic rd_a0_r;
  logic rd_dma_r;
  logic wr_dma_r;
  logic wr_a0_r;
  logic [7:0] wr_data_r;

  // ----------------------------------------------------------------
  // Decode of the current opcode
  // ----------------------------------------------------------------
  logic run;
  logic sec;
  logic [7:0] cur_op;
  logic [7:0] imm;
  logic d_anl_p, d_orl_p, d_in_p, d_outl_p;
  logic d_xrd, d_xwr, d_xand, d_xor, is_exp;
  logic d_mov_r_imm, d_mov_i_imm, d_mov_i_a, d_xch, d_digit_xchg;
  logic d_mov_a_imm, d_in_host, d_out_host, d_status_ld;
  logic d_movp, d_movp3, d_tirq_en, d_tirq_dis, d_dma_en, d_rb0, d_rb1;
  logic two_byte;
  logic two_cyc;

  assign run = (st_r == S_RUN);
  assign sec = (st_r == S_SEC);
  assign cur_op = sec ? op_r : pmem_r[pc_r];
  assign imm = pmem_r[pc_r];
  assign d_anl_p = (cur_op & OP_MASK_P) == OP_ANL_P;
  assign d_orl_p = (cur_op & OP_MASK_P) == OP_ORL_P;
  assign d_in_p = (cur_op & OP_MASK_P) == OP_IN_P;
  assign d_outl_p = (cur_op & OP_MASK_P) == OP_OUTL_P;
  assign d_xrd = (cur_op & OP_MASK_P) == OP_EXP_RD;
  assign d_xwr = (cur_op & OP_MASK_P) == OP_EXP_WR;
  assign d_xand = (cur_op & OP_MASK_P) == OP_EXP_AND;
  assign d_xor = (cur_op & OP_MASK_P) == OP_EXP_OR;
  assign is_exp = d_xrd | d_xwr | d_xand | d_xor;
  assign d_mov_r_imm = (cur_op & OP_MASK_R) == OP_MOV_R_IMM;
  assign d_mov_i_imm = (cur_op & OP_MASK_I) == OP_MOV_I_IMM;
  assign d_mov_i_a = (cur_op & OP_MASK_I) == OP_MOV_I_A;
  assign d_xch = (cur_op & OP_MASK_I) == OP_XCH_I;
  assign d_digit_xchg = (cur_op & OP_MASK_I) == OP_DIGIT_XCHG;
  assign d_mov_a_imm = cur_op == OP_MOV_A_IMM;
  assign d_in_host = cur_op == OP_IN_HOST;
  assign d_out_host = cur_op == OP_OUT_HOST;
  assign d_status_ld = cur_op == OP_STATUS_LD; // RL21
  assign d_movp = cur_op == OP_MOVP;
  assign d_movp3 = cur_op == OP_MOVP3;
  assign d_tirq_en = cur_op == OP_TIRQ_EN;
  assign d_tirq_dis = cur_op == OP_TIRQ_DIS;
  assign d_dma_en = cur_op == OP_DMA_EN;
  assign d_rb0 = cur_op == OP_BANK0;
  assign d_rb1 = cur_op == OP_BANK1;
  // Length and cycle classes
  assign two_byte = d_anl_p | d_orl_p | d_mov_r_imm | d_mov_i_imm
                  | d_mov_a_imm; // RL23
  assign two_cyc = two_byte | d_in_p | d_outl_p | is_exp | d_movp | d_movp3;

  // ----------------------------------------------------------------
  // Sequencer: one machine cycle per clock
  // ----------------------------------------------------------------
  // State and program counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= S_HALT;
      pc_r <= PCX_PC_RST;
      op_r <= PCX_ACC_RST;
    end else begin
      case (st_r)
        S_HALT: begin
          if (run_r) st_r <= S_RUN;
        end
        S_RUN: begin
          op_r <= cur_op;
          pc_r <= pc_r + 10'd1;
          if (two_cyc) st_r <= S_SEC;
          else if (!run_r) st_r <= S_HALT;
        end
        S_SEC: begin
          if (two_byte) pc_r <= pc_r + 10'd1; // RL23 RL11 RL12
          st_r <= run_r ? S_RUN : S_HALT;
        end
        default: st_r <= S_HALT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data memory and working registers
  // ----------------------------------------------------------------
  logic [5:0] bank_base;
  logic [5:0] ptr_idx;
  logic [5:0] ind_addr;
  logic [7:0] ind_data;
  logic dm_we;
  logic [5:0] dm_wa;
  logic [7:0] dm_wd;

  assign bank_base = bank_r ? PCX_BANK1_BASE : PCX_BANK0_BASE;
  assign ptr_idx = bank_base | {5'h00, cur_op[0]};
  assign ind_addr = dmem_r[ptr_idx][5:0];
  assign ind_data = dmem_r[ind_addr];

  // Single write port shared by the data moves
  always_comb begin
    dm_we = 1'b0;
    dm_wa = ind_addr;
    dm_wd = acc_r;
    if (sec && d_mov_r_imm) begin
      dm_we = 1'b1; // RL11
      dm_wa = bank_base | {3'h0, cur_op[2:0]};
      dm_wd = imm;
    end else if (sec && d_mov_i_imm) begin
      dm_we = 1'b1; // RL12
      dm_wd = imm;
    end else if (run && (d_mov_i_a || d_xch)) begin
      dm_we = 1'b1; // RL13 RL15
    end else if (run && d_digit_xchg) begin
      dm_we = 1'b1; // RL14
      dm_wd = {ind_data[7:4], acc_r[3:0]};
    end
  end

  // Memory write
  always_ff @(posedge ref_clk) begin
    if (dm_we) dmem_r[dm_wa] <= dm_wd;
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_r <= PCX_ACC_RST;
    end else if (run) begin
      if (d_in_host) acc_r <= in_buf_r; // RL3
      else if (d_xch) acc_r <= ind_data; // RL15
      else if (d_digit_xchg) acc_r <= {acc_r[7:4], ind_data[3:0]}; // RL14
    end else if (sec) begin
      if (d_mov_a_imm) acc_r <= imm;
      else if (d_in_p) acc_r <= cur_op[1] ? p2_i : p1_i;
      else if (d_xrd) acc_r <= {4'h0, p2_i[3:0]}; // RL6
      else if (d_movp) acc_r <= pmem_r[{pc_r[9:8], acc_r}]; // RL10
      else if (d_movp3) acc_r <= pmem_r[{PCX_PAGE3, acc_r}]; // RL10
    end
  end

  // ----------------------------------------------------------------
  // Ports 1 and 2, expander strobe, DMA handshake
  // ----------------------------------------------------------------
  logic [7:0] port_old;
  logic [7:0] port_new;
  logic port_wr;
  logic p2_wr;
  logic dma_set;
  logic dma_ack_evt;
  logic rd_evt;
  logic wr_evt;

  assign port_old = cur_op[1] ? p2_r : p1_r;
  assign port_new = d_anl_p ? (port_old & imm) : // RL1
                    d_orl_p ? (port_old | imm) : acc_r; // RL2
  assign port_wr = sec && (d_anl_p || d_orl_p || d_outl_p);
  assign p2_wr = port_wr && cur_op[1];
  assign dma_set = p2_wr && dma_en_r && port_new[PCX_DMA_REQ_BIT];
  assign dma_ack_evt = (rd_evt && rd_dma_r) || (wr_evt && wr_dma_r);

  // Port latches
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      p1_r <= PCX_PORT_RST;
      p2_r <= PCX_PORT_RST;
    end else if (port_wr) begin
      if (cur_op[1]) p2_r <= port_new; // RL1 RL2
      else p1_r <= port_new; // RL1 RL2
    end
  end

  // Handshake enable and request; a new request wins over a drop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dma_en_r <= 1'b0;
      dma_req_r <= 1'b0;
    end else begin
      if (run && d_dma_en) dma_en_r <= 1'b1; // RL18
      if (dma_set) dma_req_r <= 1'b1;
      else if (dma_ack_evt || (run && d_dma_en)) dma_req_r <= 1'b0; // RL22
    end
  end

  // Expander: command nibble with strobe high, then data with strobe low
  always_comb begin
    exp_o = '0;
    if (run && is_exp) begin
      exp_o.strobe = 1'b1; // RL6 RL7 RL8 RL9
      exp_o.lo_oe = 1'b1;
      exp_o.lo[1:0] = cur_op[1:0];
      exp_o.lo[3:2] = d_xrd ? EXP_CMD_RD : d_xwr ? EXP_CMD_WR :
                      d_xor ? EXP_CMD_OR : EXP_CMD_AND;
    end else if (sec && is_exp && !d_xrd) begin
      exp_o.lo_oe = 1'b1; // RL7 RL8 RL9
      exp_o.lo = acc_r[3:0];
    end
  end

  // Pin view of the ports; upper port 2 lines follow the handshake
  always_comb begin
    p1_o = p1_r;
    p2_o = p2_r;
    if (exp_o.lo_oe) p2_o[3:0] = exp_o.lo;
    if (dma_en_r) p2_o[7:6] = {1'b1, dma_req_r}; // RL18
  end
  assign dma_request_line = dma_req_r;

  // ----------------------------------------------------------------
  // Bank select and timer interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_r <= 1'b0;
      tirq_en_r <= 1'b0;
    end else if (run) begin
      if (d_rb0) bank_r <= 1'b0; // RL19
      else if (d_rb1) bank_r <= 1'b1; // RL19
      if (d_tirq_en) tirq_en_r <= 1'b1; // RL16
      else if (d_tirq_dis) tirq_en_r <= 1'b0; // RL17
    end
  end
  assign timer_irq_enable = tirq_en_r;

  // ----------------------------------------------------------------
  // Host data buffer and status
  // ----------------------------------------------------------------
  logic host_sel;
  logic dma_sel;
  logic rd_act;
  logic wr_act;
  logic eff_a0;
  logic [7:0] status;

  assign host_sel = !host_in.cs_n;
  assign dma_sel = dma_en_r && !host_in.dma_acknowledge_line_n;
  assign eff_a0 = host_in.a0 && !dma_sel;
  assign rd_act = (host_sel || dma_sel) && !host_in.rd_n;
  assign wr_act = (host_sel || dma_sel) && !host_in.wr_n;
  assign rd_evt = rd_act_r && !rd_act;
  assign wr_evt = wr_act_r && !wr_act;
  assign status = {host_status_nibble_r, f1_r, 1'b0, in_full_r, out_full_r};

  // Strobe tracking; data and address caught while the strobe is low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      rd_a0_r <= 1'b0;
      rd_dma_r <= 1'b0;
      wr_dma_r <= 1'b0;
      wr_a0_r <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      rd_act_r <= rd_act;
      wr_act_r <= wr_act;
      if (rd_act) begin
        rd_a0_r <= eff_a0;
        rd_dma_r <= dma_sel;
      end
      if (wr_act) begin
        wr_a0_r <= eff_a0;
        wr_dma_r <= dma_sel;
        wr_data_r <= host_in.data;
      end
    end
  end

  // Buffers and flags; a set wins over a clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_full_r <= 1'b0;
      out_full_r <= 1'b0;
      f1_r <= 1'b0;
      in_buf_r <= 8'h00;
      out_buf_r <= 8'h00;
      host_status_nibble_r <= 4'h0;
    end else begin
      if (wr_evt) begin
        in_full_r <= 1'b1;
        in_buf_r <= wr_data_r;
        f1_r <= wr_a0_r;
      end else if (run && d_in_host) begin
        in_full_r <= 1'b0; // RL3
      end
      if (run && d_out_host) begin
        out_full_r <= 1'b1; // RL4
        out_buf_r <= acc_r; // RL4
      end else if (rd_evt && !rd_a0_r) begin
        out_full_r <= 1'b0;
      end
      if (run && d_status_ld) host_status_nibble_r <= acc_r[7:4]; // RL5 RL20
    end
  end

  // Host read data
  always_ff @(posedge ref_clk) begin
    if (sys_rst) host_dout <= 8'h00;
    else host_dout <= eff_a0 ? status : out_buf_r;
  end
  assign host_doe = rd_act;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic apb_wr;
  logic addr_ok;

  assign apb_wr = psel && penable && pwrite;
  assign addr_ok = (paddr == PCX_CTRL_OFS) || (paddr == PCX_PADDR_OFS)
                || (paddr == PCX_PDATA_OFS) || (paddr == PCX_CORE_OFS)
                || (paddr == PCX_HOST_OFS) || (paddr == PCX_DADDR_OFS)
                || (paddr == PCX_DDATA_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Writable registers and program memory loading
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      pm_addr_r <= 10'h000;
      dm_addr_r <= 6'h00;
    end else if (apb_wr) begin
      case (paddr)
        PCX_CTRL_OFS: run_r <= pwdata[PCX_CTRL_RUN_BIT];
        PCX_PADDR_OFS: pm_addr_r <= pwdata[9:0];
        PCX_PDATA_OFS: pm_addr_r <= pm_addr_r + 10'd1;
        PCX_DADDR_OFS: dm_addr_r <= pwdata[5:0];
        default: run_r <= run_r;
      endcase
    end
  end

  // Program memory store
  always_ff @(posedge ref_clk) begin
    if (apb_wr && paddr == PCX_PDATA_OFS) pmem_r[pm_addr_r] <= pwdata[7:0];
  end

  // Read data captured in the setup phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        PCX_CTRL_OFS: prdata <= {31'h0000_0000, run_r};
        PCX_PADDR_OFS: prdata <= {22'h00_0000, pm_addr_r};
        PCX_PDATA_OFS: prdata <= {24'h00_0000, pmem_r[pm_addr_r]};
        PCX_CORE_OFS: prdata <= {10'h000, dma_req_r, dma_en_r, tirq_en_r,
                                 bank_r, pc_r, acc_r};
        PCX_HOST_OFS: prdata <= {8'h00, in_buf_r, out_buf_r, status};
        PCX_DADDR_OFS: prdata <= {26'h000_0000, dm_addr_r};
        PCX_DDATA_OFS: prdata <= {24'h00_0000, dmem_r[dm_addr_r]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence exp_cmd_s;
    run && d_xrd && exp_o.strobe;
  endsequence
  sequence exp_data_s;
    sec && !exp_o.strobe ##1 !sec;
  endsequence

  port_and_a: assert property (sec && d_anl_p && !cur_op[1] |=> // RL1
    p1_r == ($past(p1_r) & $past(imm)))
    else $error("port AND result wrong");
  port_or_a: assert property (run && d_orl_p && !cur_op[1] |=> // RL2
    sec ##1 p1_r == ($past(p1_r, 2) | $past(imm)))
    else $error("port OR result wrong");
  ibuf_clear_a: assert property (run && d_in_host |=> // RL3
    (!in_full_r || $past(wr_evt)) && acc_r == $past(in_buf_r))
    else $error("input buffer read wrong");
  obuf_set_a: assert property (run && d_out_host |=> // RL4
    out_full_r && out_buf_r == $past(acc_r))
    else $error("output buffer write wrong");
  nibble_load_a: assert property (run && cur_op == 8'h90 |=> // RL5
    host_status_nibble_r == $past(acc_r[7:4]))
    else $error("status nibble not loaded");
  flags_keep_a: assert property (run && d_status_ld && !rd_evt && !wr_evt
    |=> status[3:0] == $past(status[3:0])) // RL20
    else $error("status flags disturbed");
  exp_read_a: assert property (exp_cmd_s |=> exp_data_s) // RL6
    else $error("expander read sequence wrong");
  imm_reg_a: assert property (run && d_mov_r_imm |=> // RL11
    sec ##1 pc_r == $past(pc_r, 2) + 10'd2)
    else $error("immediate load length wrong");
  bank_sel_a: assert property (run && d_rb1 |=> bank_r) // RL19
    else $error("bank one not selected");
  tirq_ctl_a: assert property (run && d_tirq_dis |=> !tirq_en_r) // RL17
    else $error("timer interrupt not disabled");
  dma_drop_a: assert property (dma_req_r && dma_ack_evt && !dma_set // RL22
    |=> !dma_req_r)
    else $error("DMA request not dropped");

endmodule : pcx_core

/* File: sim/pcx_host_model.sv */
// Master processor model that drives the host data buffer strobes
`timescale 1ns/1ps
module pcx_host_model
  import pcx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] host_dout,
  output pcx_host_in_t host_in
);
  // Idle: all strobes high, nothing selected
  initial host_in = {5'b11101, 8'h00};

  // One transfer: strobe low two cycles, high two; ack means DMA access
  task automatic xfer(input logic wr, input logic ack, input logic a0,
                      input logic [7:0] d, output logic [7:0] q);
    host_in.cs_n <= ack;
    host_in.dma_acknowledge_line_n <= !ack;
    host_in.a0 <= a0;
    host_in.rd_n <= wr;
    host_in.wr_n <= !wr;
    host_in.data <= d;
    repeat (2) @(posedge ref_clk);
    q = host_dout;
    host_in.rd_n <= 1'b1;
    host_in.wr_n <= 1'b1;
    host_in.cs_n <= 1'b1;
    host_in.dma_acknowledge_line_n <= 1'b1;
    // Released bus has no pull, so show a changed value
    host_in.data <= ~d;
    repeat (2) @(posedge ref_clk);
  endtask : xfer
endmodule : pcx_host_model

/* File: sim/testbench.sv */
// Self-checking bench for the instruction unit
`timescale 1ns/1ps
module testbench
  import pcx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, perr, host_doe, dma_request_line, timer_irq_enable;
  logic [7:0] host_dout, p1_o, p2_o, q;
  logic [7:0] p1_i = 8'hFF;
  logic [7:0] p2_i = 8'hF6;
  logic [15:0] cmds = 16'h0000;
  int n_doe = 0;
  pcx_host_in_t host_in;
  pcx_exp_out_t exp_o;
  int num_errors = 0;
  int n_checks = 0;

  pcx_core i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_in(host_in),
    .host_dout(host_dout), .host_doe(host_doe), .p1_i(p1_i), .p1_o(p1_o),
    .p2_i(p2_i), .p2_o(p2_o), .exp_o(exp_o),
    .dma_request_line(dma_request_line),
    .timer_irq_enable(timer_irq_enable));
  pcx_host_model i_host (.ref_clk(ref_clk), .host_dout(host_dout),
    .host_in(host_in));

  // Clock, 50 ns period
  initial forever #25 ref_clk = ~ref_clk;

  // Record expander command nibbles and host read-enable cycles
  always @(posedge ref_clk) begin
    if (exp_o.strobe === 1'b1) cmds <= {cmds[11:0], exp_o.lo};
    if (host_doe === 1'b1) n_doe <= n_doe + 1;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reset for two cycles, then write a 16-byte program at address 0
  task automatic load(input logic [7:0] p[$]);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b1, PCX_PADDR_OFS, 32'h0000_0000);
    for (int i = 0; i < 16; i++)
      apb(1'b1, PCX_PDATA_OFS, {24'h00_0000, i < p.size() ? p[i] : 8'h00});
  endtask : load

  task automatic go(input int n);
    apb(1'b1, PCX_CTRL_OFS, 32'h0000_0001);
    repeat (n) @(posedge ref_clk);
    apb(1'b1, PCX_CTRL_OFS, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
  endtask : go

  task automatic dmem(input logic [5:0] a, input logic [7:0] e);
    apb(1'b1, PCX_DADDR_OFS, {26'h000_0000, a});
    apb(1'b0, PCX_DDATA_OFS, 32'h0000_0000);
    chk("dmem", {24'h00_0000, e}, rdat);
  endtask : dmem

  task automatic s_reset();
    load('{8'h00});
    apb(1'b0, PCX_CORE_OFS, 32'h0000_0000);
    chk("core", 32'h0000_0000, rdat);
    apb(1'b0, PCX_HOST_OFS, 32'h0000_0000);
    chk("host", 32'h0000_0000, rdat);
    chk("p1", 32'h0000_00FF, {24'h00_0000, p1_o});
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, perr});
  endtask : s_reset

  // Enable, AND, OR, disable: enable must stand exactly 2+2+1 cycles
  task automatic s_port();
    int n;
    load('{8'h25, 8'h99, 8'hF3, 8'h89, 8'h08, 8'h35});
    apb(1'b1, PCX_CTRL_OFS, 32'h0000_0001);
    n = 0;
    while (timer_irq_enable !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 50) begin
      num_errors++;
      tally_and_finish();
    end
    n = 0;
    while (timer_irq_enable !== 1'b0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    chk("irq_en_cycles", 32'd5, n);
    chk("p1", 32'h0000_00FB, {24'h00_0000, p1_o});
    go(2);
  endtask : s_port

  task automatic s_host();
    load('{8'h22, 8'h02, 8'h90});
    i_host.xfer(1'b1, 1'b0, 1'b0, 8'h5C, q);
    apb(1'b0, PCX_HOST_OFS, 32'h0000_0000);
    chk("host_in", 32'h005C_0002, rdat);
    go(10);
    apb(1'b0, PCX_HOST_OFS, 32'h0000_0000);
    chk("host_run", 32'h005C_5C51, rdat);
    i_host.xfer(1'b0, 1'b0, 1'b0, 8'h00, q);
    chk("data_rd", 32'h0000_005C, {24'h00_0000, q});
    i_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk("status_rd", 32'h0000_0050, {24'h00_0000, q});
  endtask : s_host

  task automatic s_data();
    load('{8'hB8, 8'h10, 8'hB0, 8'h3C, 8'h23, 8'h9A, 8'h30, 8'h20,
           8'hE3, 8'hD5, 8'hB8, 8'h20, 8'hA0});
    go(30);
    dmem(6'h10, 8'h9C);
    dmem(6'h18, 8'h20);
    dmem(6'h20, 8'h77);
    apb(1'b0, PCX_CORE_OFS, 32'h0000_0000);
    chk("core", 32'h0004_0077, rdat & 32'h0004_00FF);
  endtask : s_data

  task automatic s_exp_dma();
    load('{8'hE5, 8'h23, 8'h40, 8'h3A, 8'h23, 8'h5A, 8'h3D, 8'h0C,
           8'h8E, 8'h9F});
    go(30);
    chk("exp_cmds", 32'h0000_50AF, {16'h0000, cmds});
    apb(1'b0, PCX_CORE_OFS, 32'h0000_0000);
    chk("core", 32'h0030_0006, rdat & 32'h0030_000F);
    chk("p2_hi", 32'h0000_0003, {30'h0, p2_o[7:6]});
    i_host.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
    chk("drq", 32'h0000_0000, {31'h0, dma_request_line});
    chk("doe_cycles", 32'd6, n_doe);
  endtask : s_exp_dma

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b1, PCX_PADDR_OFS, 32'h0000_033A);
    apb(1'b1, PCX_PDATA_OFS, 32'h0000_0077);
    apb(1'b1, PCX_PADDR_OFS, 32'h0000_0000);
    repeat (64) apb(1'b1, PCX_PDATA_OFS, 32'h0000_0000);
    s_reset();
    s_port();
    s_host();
    s_data();
    s_exp_dma();
    tally_and_finish();
  end
endmodule : testbench
